// ### rtl/tsm_consts.svh
// Register offsets, field positions, reset values and counts of the throttle scaling and map block
`ifndef TSM_CONSTS_SVH
`define TSM_CONSTS_SVH

`define TSM_REG_TPS_CLOSED  12'h000
`define TSM_REG_TPS_OPEN    12'h004
`define TSM_REG_SETUP       12'h008
`define TSM_REG_SAVE        12'h00c
`define TSM_REG_STATUS      12'h010
`define TSM_REG_TPS_PCT     12'h014
`define TSM_REG_MAP_OUT     12'h018
`define TSM_REG_SPD_BASE    12'h040
`define TSM_REG_LOAD_BASE   12'h080
`define TSM_REG_MAP_BASE    12'h400

`define TSM_SETUP_MAP_BIT   0
`define TSM_SETUP_LOAD_BIT  1

`define TSM_RST_TPS_CLOSED  8'h00
`define TSM_RST_TPS_OPEN    8'hff
`define TSM_RST_SETUP       2'h0
`define TSM_PCT_FULL        8'h64

`define TSM_SPD_SITES       15
`define TSM_LOAD_SITES      12
`define TSM_FRAC_BITS       8

`endif

// ### rtl/tsm_pkg.sv
// Types shared by the throttle scaling and map interpolation block
package tsm_pkg;
	typedef enum logic [2:0] {
		TSM_IDLE = 3'b000,
		TSM_SPD  = 3'b001,
		TSM_LOAD = 3'b010,
		TSM_ROW0 = 3'b011,
		TSM_ROW1 = 3'b100,
		TSM_COL  = 3'b101
	} tsm_state_e;

	typedef enum logic [1:0] {
		TSM_DIV_IDLE = 2'b00,
		TSM_DIV_RUN  = 2'b01,
		TSM_DIV_FIN  = 2'b10
	} tsm_div_e;
endpackage

// ### rtl/tsm_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module tsm_sync #(
	parameter int W = 8
) (
	input  wire logic         sys_clk_i,
	input  wire logic         reset_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	for (genvar b = 0; b < W; b++) begin : g_bit
		always_ff @(posedge sys_clk_i) begin
			if (reset_i) begin
				meta[b] <= 1'b0;
				q_o[b]  <= 1'b0;
			end else begin
				meta[b] <= d_i[b];
				q_o[b]  <= meta[b];
			end
		end
	end
endmodule

// ### rtl/tsm_interp.sv
// Linear interpolation between two sites with clamping at both ends
`timescale 1ns/1ps
`include "tsm_consts.svh"
module tsm_interp #(
	parameter int XW = 16
) (
	input  wire logic          sys_clk_i,
	input  wire logic          reset_i,
	input  wire logic          start_i,
	input  wire logic [XW-1:0] x_i,
	input  wire logic [XW-1:0] x0_i,
	input  wire logic [XW-1:0] x1_i,
	input  wire logic [7:0]    y0_i,
	input  wire logic [7:0]    y1_i,
	output logic      [7:0]    y_o,
	output logic               done_o
);
	tsm_pkg::tsm_div_e  st, next_st;
	logic [XW:0]        rem, next_rem;
	logic [XW-1:0]      den, next_den;
	logic [7:0]         frac, next_frac;
	logic [3:0]         cnt, next_cnt;
	logic signed [8:0]  dy, next_dy;
	logic [7:0]         ybase, next_ybase;
	logic [7:0]         next_y;
	logic               next_done;
	logic [XW:0]        shifted;
	logic signed [17:0] prod;
	logic signed [9:0]  ysum;

	always_comb begin
		next_st    = st;
		next_rem   = rem;
		next_den   = den;
		next_frac  = frac;
		next_cnt   = cnt;
		next_dy    = dy;
		next_ybase = ybase;
		next_y     = y_o;
		next_done  = 1'b0;
		shifted    = {rem[XW-1:0], 1'b0};
		prod       = dy * $signed({1'b0, frac});
		ysum       = $signed({2'b00, ybase}) + $signed(prod[17:8]);
		case (st)
			tsm_pkg::TSM_DIV_IDLE: begin
				if (start_i) begin
					// Clamp outside the bracket, and on a reversed or empty bracket
					if (x1_i <= x0_i || x_i <= x0_i) begin
						next_y    = y0_i;
						next_done = 1'b1;
					end else if (x_i >= x1_i) begin
						next_y    = y1_i;
						next_done = 1'b1;
					end else begin
						next_rem   = {1'b0, x_i - x0_i};
						next_den   = x1_i - x0_i;
						next_ybase = y0_i;
						next_dy    = $signed({1'b0, y1_i}) - $signed({1'b0, y0_i});
						next_cnt   = 4'h0;
						next_frac  = 8'h00;
						next_st    = tsm_pkg::TSM_DIV_RUN;
					end
				end
			end
			tsm_pkg::TSM_DIV_RUN: begin
				// Restoring division gives the fraction of the way across the bracket
				if (shifted >= {1'b0, den}) begin
					next_rem  = shifted - {1'b0, den};
					next_frac = {frac[6:0], 1'b1};
				end else begin
					next_rem  = shifted;
					next_frac = {frac[6:0], 1'b0};
				end
				next_cnt = cnt + 4'h1;
				if (cnt == 4'(`TSM_FRAC_BITS - 1))
					next_st = tsm_pkg::TSM_DIV_FIN;
			end
			tsm_pkg::TSM_DIV_FIN: begin
				next_y    = ysum[7:0]; // R8
				next_done = 1'b1;
				next_st   = tsm_pkg::TSM_DIV_IDLE;
			end
			default: next_st = tsm_pkg::TSM_DIV_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st     <= tsm_pkg::TSM_DIV_IDLE;
			rem    <= '0;
			den    <= '0;
			frac   <= 8'h00;
			cnt    <= 4'h0;
			dy     <= 9'sh000;
			ybase  <= 8'h00;
			y_o    <= 8'h00;
			done_o <= 1'b0;
		end else begin
			st     <= next_st;
			rem    <= next_rem;
			den    <= next_den;
			frac   <= next_frac;
			cnt    <= next_cnt;
			dy     <= next_dy;
			ybase  <= next_ybase;
			y_o    <= next_y;
			done_o <= next_done;
		end
	end

	interp_bound_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R8
		st == tsm_pkg::TSM_DIV_FIN |=> (dy >= 0) ? (y_o >= ybase && 10'(y_o) <= 10'(ybase) + 10'(dy))
			: (y_o <= ybase && 10'(y_o) >= 10'(ybase) - 10'(-dy)))
		else $error("interpolated value outside its bracket");
	interp_time_a: assert property (@(posedge sys_clk_i) disable iff (reset_i) // R7
		(start_i && st == tsm_pkg::TSM_DIV_IDLE) |-> ##[1:10] done_o)
		else $error("interpolation did not finish in time");
endmodule

// ### rtl/tsm_top.sv
// Throttle position scaling and 3D map lookup with switchable interpolation
//
// Overview of operation
// R1: Raw throttle sample and both calibration points are unsigned 0 to 255.
// R2: Raw throttle maps to 0..100 percent between closed and open points.
// R3: Host must write closed below open; reversed pair is flagged as fault.
// R4: Save command copies closed and open points into the persistent bank.
// R5: One fifteen-site speed axis, sites 0 to 14, shared by every map.
// R6: Load input is pressure or throttle percent, by stored selection.
// R7: With interpolation on, output comes from the bracketing sites.
// R8: Interpolation between bracketing sites is linear.
// R9: Mapping mode disables interpolation; each output depends on one site.
// R10: Mapping-mode change takes effect only after a save command.
// R11: Without interpolation, use site at or below input, clamped to ends.
`timescale 1ns/1ps
`include "tsm_consts.svh"
module tsm_top #(
	parameter int SPD_N  = `TSM_SPD_SITES,
	parameter int LOAD_N = `TSM_LOAD_SITES
) (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic [11:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	input  wire logic [7:0]  tps_raw_i,
	input  wire logic [7:0]  map_kpa_i,
	input  wire logic [15:0] rpm_i,
	output logic      [7:0]  tps_pct_o,
	output logic      [7:0]  map_out_o,
	output logic             map_valid_o,
	output logic             map_mode_o,
	output logic             load_sel_tps_o,
	output logic             cal_fault_o
);
	localparam int MAP_N = SPD_N * LOAD_N;

	// Register file and calibration
	logic [7:0]  staged_closed, next_staged_closed;
	logic [7:0]  staged_open, next_staged_open;
	logic [1:0]  staged_setup, next_staged_setup;
	logic [7:0]  nv_closed, next_nv_closed;
	logic [7:0]  nv_open, next_nv_open;
	logic [1:0]  next_nv_setup;
	logic        next_cal_fault;
	logic [31:0] next_rdata;
	logic [15:0] spd_axis [SPD_N];
	logic [7:0]  load_axis [LOAD_N];
	logic [7:0]  map_mem [MAP_N];
	logic        save_wr;
	logic        spd_hit, load_hit, map_hit;
	logic [3:0]  ax_idx;
	logic [7:0]  map_idx;

	assign save_wr  = wr_i && addr_i == `TSM_REG_SAVE;
	assign ax_idx   = addr_i[5:2];
	assign map_idx  = addr_i[9:2];
	assign spd_hit  = addr_i[11:6] == 6'(`TSM_REG_SPD_BASE >> 6) && int'(ax_idx) < SPD_N;
	assign load_hit = addr_i[11:6] == 6'(`TSM_REG_LOAD_BASE >> 6) && int'(ax_idx) < LOAD_N;
	assign map_hit  = addr_i[11:10] == 2'(`TSM_REG_MAP_BASE >> 10) && int'(map_idx) < MAP_N;

	always_comb begin
		next_staged_closed = staged_closed;
		next_staged_open   = staged_open;
		next_staged_setup  = staged_setup;
		next_nv_closed     = nv_closed;
		next_nv_open       = nv_open;
		next_nv_setup      = {load_sel_tps_o, map_mode_o};
		if (wr_i) begin
			case (addr_i)
				`TSM_REG_TPS_CLOSED: next_staged_closed = wdata_i[7:0]; // R1
				`TSM_REG_TPS_OPEN:   next_staged_open   = wdata_i[7:0]; // R1
				`TSM_REG_SETUP:      next_staged_setup  = wdata_i[1:0];
				default:             next_staged_setup  = staged_setup;
			endcase
		end
		if (save_wr) begin
			next_nv_closed = staged_closed; // R4
			next_nv_open   = staged_open;   // R4
			next_nv_setup  = staged_setup;  // R10
		end
		next_cal_fault = nv_closed >= nv_open; // R3
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			staged_closed  <= `TSM_RST_TPS_CLOSED;
			staged_open    <= `TSM_RST_TPS_OPEN;
			staged_setup   <= `TSM_RST_SETUP;
			nv_closed      <= `TSM_RST_TPS_CLOSED;
			nv_open        <= `TSM_RST_TPS_OPEN;
			map_mode_o     <= 1'(`TSM_RST_SETUP >> `TSM_SETUP_MAP_BIT);
			load_sel_tps_o <= 1'(`TSM_RST_SETUP >> `TSM_SETUP_LOAD_BIT);
			cal_fault_o    <= 1'b0;
		end else begin
			staged_closed  <= next_staged_closed;
			staged_open    <= next_staged_open;
			staged_setup   <= next_staged_setup;
			nv_closed      <= next_nv_closed;
			nv_open        <= next_nv_open;
			map_mode_o     <= next_nv_setup[`TSM_SETUP_MAP_BIT];
			load_sel_tps_o <= next_nv_setup[`TSM_SETUP_LOAD_BIT];
			cal_fault_o    <= next_cal_fault;
		end
	end

	// Axis and map tables take effect at once
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			for (int i = 0; i < SPD_N; i++)
				spd_axis[i] <= 16'h0000;
			for (int i = 0; i < LOAD_N; i++)
				load_axis[i] <= 8'h00;
			for (int i = 0; i < MAP_N; i++)
				map_mem[i] <= 8'h00;
		end else if (wr_i) begin
			if (spd_hit)
				spd_axis[ax_idx] <= wdata_i[15:0]; // R5
			if (load_hit)
				load_axis[ax_idx] <= wdata_i[7:0];
			if (map_hit)
				map_mem[map_idx] <= wdata_i[7:0];
		end
	end

	// Read data in the cycle after the strobe, zero elsewhere
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_i) begin
			if (spd_hit)
				next_rdata = {16'h0000, spd_axis[ax_idx]};
			else if (load_hit)
				next_rdata = {24'h00_0000, load_axis[ax_idx]};
			else if (map_hit)
				next_rdata = {24'h00_0000, map_mem[map_idx]};
			else begin
				case (addr_i)
					`TSM_REG_TPS_CLOSED: next_rdata = {24'h00_0000, staged_closed};
					`TSM_REG_TPS_OPEN:   next_rdata = {24'h00_0000, staged_open};
					`TSM_REG_SETUP:      next_rdata = {30'h0000_0000, staged_setup};
					`TSM_REG_STATUS:     next_rdata = {29'h0000_0000, cal_fault_o, load_sel_tps_o, map_mode_o};
					`TSM_REG_TPS_PCT:    next_rdata = {24'h00_0000, tps_pct_o};
					`TSM_REG_MAP_OUT:    next_rdata = {24'h00_0000, map_out_o};
					default:             next_rdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i)
			rdata_o <= 32'h0000_0000;
		else
			rdata_o <= next_rdata;
	end

	// Throttle scaling runs back to back on the synchronised sample
	logic [7:0] tps_raw_s;
	logic       tps_kick, next_tps_kick;
	logic [7:0] tps_y, next_tps_pct;
	logic       tps_done;

	tsm_sync #(.W(8)) u_tps_sync (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.d_i       (tps_raw_i),
		.q_o       (tps_raw_s)
	);

	tsm_interp #(.XW(8)) u_tps_scale (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.start_i   (tps_kick),
		.x_i       (tps_raw_s),
		.x0_i      (nv_closed),
		.x1_i      (nv_open),
		.y0_i      (8'h00),
		.y1_i      (`TSM_PCT_FULL),
		.y_o       (tps_y),
		.done_o    (tps_done)
	);

	always_comb begin
		next_tps_kick = tps_done;
		next_tps_pct  = tps_done ? tps_y : tps_pct_o; // R2
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			tps_kick  <= 1'b1;
			tps_pct_o <= 8'h00;
		end else begin
			tps_kick  <= next_tps_kick;
			tps_pct_o <= next_tps_pct;
		end
	end

	// Map lookup: bracket search on both axes, then three interpolation passes, or a single site read in mapping mode
	tsm_pkg::tsm_state_e state, next_state;
	logic [3:0]  sidx, next_sidx, lidx, next_lidx, sidx_hi, lidx_hi;
	logic [15:0] spd, next_spd;
	logic [7:0]  ld, next_ld, row0, next_row0, row1, next_row1, next_map_out;
	logic        istart, next_istart, next_map_valid;
	logic [15:0] ix, ix0, ix1;
	logic [7:0]  iy0, iy1, iy;
	logic        idone;

	assign sidx_hi = int'(sidx) < SPD_N - 1 ? sidx + 4'h1 : sidx;
	assign lidx_hi = int'(lidx) < LOAD_N - 1 ? lidx + 4'h1 : lidx;

	always_comb begin
		next_state     = state;
		next_sidx      = sidx;
		next_lidx      = lidx;
		next_spd       = spd;
		next_ld        = ld;
		next_row0      = row0;
		next_row1      = row1;
		next_map_out   = map_out_o;
		next_map_valid = 1'b0;
		next_istart    = 1'b0;
		ix  = spd;
		ix0 = spd_axis[sidx];
		ix1 = spd_axis[sidx_hi];
		iy0 = map_mem[8'(int'(sidx) * LOAD_N + int'(lidx))];
		iy1 = map_mem[8'(int'(sidx_hi) * LOAD_N + int'(lidx))];
		if (state == tsm_pkg::TSM_ROW1) begin
			iy0 = map_mem[8'(int'(sidx) * LOAD_N + int'(lidx_hi))];
			iy1 = map_mem[8'(int'(sidx_hi) * LOAD_N + int'(lidx_hi))];
		end else if (state == tsm_pkg::TSM_COL) begin
			ix  = {8'h00, ld};
			ix0 = {8'h00, load_axis[lidx]};
			ix1 = {8'h00, load_axis[lidx_hi]};
			iy0 = row0;
			iy1 = row1;
		end
		case (state)
			tsm_pkg::TSM_IDLE: begin
				next_spd   = rpm_i;
				next_ld    = load_sel_tps_o ? tps_pct_o : map_kpa_i; // R6
				next_sidx  = 4'h0;
				next_lidx  = 4'h0;
				next_state = tsm_pkg::TSM_SPD;
			end
			tsm_pkg::TSM_SPD: begin
				if (int'(sidx) < SPD_N - 1 && spd_axis[sidx_hi] <= spd)
					next_sidx = sidx_hi; // R11
				else
					next_state = tsm_pkg::TSM_LOAD;
			end
			tsm_pkg::TSM_LOAD: begin
				if (int'(lidx) < LOAD_N - 1 && load_axis[lidx_hi] <= ld)
					next_lidx = lidx_hi; // R11
				else if (map_mode_o) begin
					next_map_out   = iy0; // R9
					next_map_valid = 1'b1;
					next_state     = tsm_pkg::TSM_IDLE;
				end else begin
					next_istart = 1'b1; // R7
					next_state  = tsm_pkg::TSM_ROW0;
				end
			end
			tsm_pkg::TSM_ROW0: begin
				if (idone) begin
					next_row0   = iy;
					next_istart = 1'b1;
					next_state  = tsm_pkg::TSM_ROW1;
				end
			end
			tsm_pkg::TSM_ROW1: begin
				if (idone) begin
					next_row1   = iy;
					next_istart = 1'b1;
					next_state  = tsm_pkg::TSM_COL;
				end
			end
			tsm_pkg::TSM_COL: begin
				if (idone) begin
					next_map_out   = iy; // R8
					next_map_valid = 1'b1;
					next_state     = tsm_pkg::TSM_IDLE;
				end
			end
			default: next_state = tsm_pkg::TSM_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state       <= tsm_pkg::TSM_IDLE;
			sidx        <= 4'h0;
			lidx        <= 4'h0;
			spd         <= 16'h0000;
			ld          <= 8'h00;
			row0        <= 8'h00;
			row1        <= 8'h00;
			istart      <= 1'b0;
			map_out_o   <= 8'h00;
			map_valid_o <= 1'b0;
		end else begin
			state       <= next_state;
			sidx        <= next_sidx;
			lidx        <= next_lidx;
			spd         <= next_spd;
			ld          <= next_ld;
			row0        <= next_row0;
			row1        <= next_row1;
			istart      <= next_istart;
			map_out_o   <= next_map_out;
			map_valid_o <= next_map_valid;
		end
	end

	tsm_interp #(.XW(16)) u_map_interp (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.start_i   (istart),
		.x_i       (ix),
		.x0_i      (ix0),
		.x1_i      (ix1),
		.y0_i      (iy0),
		.y1_i      (iy1),
		.y_o       (iy),
		.done_o    (idone)
	);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	spd_index_range_a: assert property (int'(sidx) < SPD_N) // R5
		else $error("speed site index beyond the axis");
	tps_pct_range_a: assert property (tps_done |=> tps_pct_o <= `TSM_PCT_FULL) // R2
		else $error("throttle percentage above full scale");
	save_commit_a: assert property (save_wr |=> nv_closed == $past(staged_closed) && nv_open == $past(staged_open)) // R4
		else $error("save did not store the calibration points");
	mode_hold_a: assert property (!save_wr |=> $stable(map_mode_o)) // R10
		else $error("mapping mode changed without a save");
	load_source_a: assert property (state == tsm_pkg::TSM_IDLE |=>
		ld == ($past(load_sel_tps_o) ? $past(tps_pct_o) : $past(map_kpa_i))) // R6
		else $error("load input taken from the wrong sensor");
	single_site_a: assert property ((state == tsm_pkg::TSM_LOAD && map_mode_o && next_state == tsm_pkg::TSM_IDLE)
		|=> map_valid_o && map_out_o == $past(iy0)) // R9
		else $error("mapping mode output is not the single site");
	interp_path_a: assert property ((state == tsm_pkg::TSM_LOAD && !map_mode_o && next_state != tsm_pkg::TSM_LOAD)
		|=> istart ##[2:40] map_valid_o) // R7
		else $error("interpolated lookup did not complete");
	fault_flag_a: assert property (##1 cal_fault_o == ($past(nv_closed) >= $past(nv_open))) // R3
		else $error("calibration fault flag wrong");
endmodule

// ### dv/tsm_sensor_model.sv
// Throttle sensor, pressure sensor and speed pickup standing at the far side of the block
`timescale 1ns/1ps
module tsm_sensor_model (
	input  wire logic        sys_clk_i,
	input  wire logic [7:0]  tps_set_i,
	input  wire logic [7:0]  kpa_set_i,
	input  wire logic [15:0] rpm_set_i,
	output logic      [7:0]  tps_raw_o,
	output logic      [7:0]  map_kpa_o,
	output logic      [15:0] rpm_o
);
	// Sensor levels move only just after a rising edge, like a sampled front end
	always_ff @(posedge sys_clk_i) begin
		tps_raw_o <= tps_set_i;
		map_kpa_o <= kpa_set_i;
		rpm_o     <= rpm_set_i;
	end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for throttle scaling and map lookup
`timescale 1ns/1ps
`include "tsm_consts.svh"
module tb_top;
	logic        sys_clk_i;
	logic        reset_i;
	logic [11:0] addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic [7:0]  tps_raw;
	logic [7:0]  map_kpa;
	logic [15:0] rpm;
	logic [7:0]  tps_set;
	logic [7:0]  kpa_set;
	logic [15:0] rpm_set;
	logic [7:0]  tps_pct_o;
	logic [7:0]  map_out_o;
	logic        map_valid_o;
	logic        map_mode_o;
	logic        load_sel_tps_o;
	logic        cal_fault_o;
	logic [31:0] rd_val;
	int          bad_count;
	int          checked;
	int          i;
	logic [7:0]  raw_tab [5] = '{8'h0a, 8'h19, 8'h7d, 8'he1, 8'hff};
	logic [7:0]  pct_tab [5] = '{8'h00, 8'h00, 8'h32, 8'h64, 8'h64};

	tsm_top tsm_top_inst (
		.sys_clk_i      (sys_clk_i),
		.reset_i        (reset_i),
		.addr_i         (addr_i),
		.wdata_i        (wdata_i),
		.wr_i           (wr_i),
		.rd_i           (rd_i),
		.rdata_o        (rdata_o),
		.tps_raw_i      (tps_raw),
		.map_kpa_i      (map_kpa),
		.rpm_i          (rpm),
		.tps_pct_o      (tps_pct_o),
		.map_out_o      (map_out_o),
		.map_valid_o    (map_valid_o),
		.map_mode_o     (map_mode_o),
		.load_sel_tps_o (load_sel_tps_o),
		.cal_fault_o    (cal_fault_o)
	);

	tsm_sensor_model tsm_sensor_model_inst (
		.sys_clk_i (sys_clk_i),
		.tps_set_i (tps_set),
		.kpa_set_i (kpa_set),
		.rpm_set_i (rpm_set),
		.tps_raw_o (tps_raw),
		.map_kpa_o (map_kpa),
		.rpm_o     (rpm)
	);

	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	task automatic stop_test();
		if (bad_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		wr_i    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe edge
	task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic save_cfg();
		bus_wr(`TSM_REG_SAVE, 32'h0000_0000);
		repeat (2) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic wait_tps();
		repeat (40) @(posedge sys_clk_i);
		#1;
	endtask

	// Two results so the second one was started from the current inputs
	task automatic wait_map();
		int n;
		// Skip a pulse raised before the new inputs reached the block
		repeat (2) @(posedge sys_clk_i);
		repeat (2) begin
			n = 0;
			@(posedge sys_clk_i);
			while (map_valid_o !== 1'b1 && n < 400) begin
				@(posedge sys_clk_i);
				n++;
			end
			if (n >= 400) begin
				chk_val(32'h0, 32'h1, "map result timeout");
			end
		end
		#1;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		bad_count++;
		stop_test();
	end

	initial begin
		bad_count = 0;
		checked   = 0;
		reset_i   = 1'b1;
		addr_i    = 12'h000;
		wdata_i   = 32'h0;
		wr_i      = 1'b0;
		rd_i      = 1'b0;
		tps_set   = 8'h00;
		kpa_set   = 8'h00;
		rpm_set   = 16'h0000;
		repeat (8) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		bus_rd(`TSM_REG_TPS_CLOSED, rd_val); chk_val(rd_val, 32'h0, "closed reset");
		bus_rd(`TSM_REG_TPS_OPEN, rd_val); chk_val(rd_val, 32'hff, "open reset");
		bus_rd(`TSM_REG_SETUP, rd_val); chk_val(rd_val, 32'h0, "setup reset");
		bus_rd(`TSM_REG_STATUS, rd_val); chk_val(rd_val, 32'h0, "status reset");
		bus_rd(12'h020, rd_val); chk_val(rd_val, 32'h0, "unmapped read");
		// Closed below open, as a correct calibration must be
		bus_wr(`TSM_REG_TPS_CLOSED, 32'h19);
		bus_wr(`TSM_REG_TPS_OPEN, 32'he1);
		bus_rd(`TSM_REG_TPS_CLOSED, rd_val); chk_val(rd_val, 32'h19, "staged closed");
		save_cfg();
		for (i = 0; i < 5; i++) begin
			tps_set <= raw_tab[i];
			wait_tps();
			chk_val({24'h0, tps_pct_o}, {24'h0, pct_tab[i]}, "throttle percent");
		end
		// Staged closed point without save must not move the scaling
		tps_set <= 8'h7d;
		bus_wr(`TSM_REG_TPS_CLOSED, 32'h7d);
		wait_tps();
		chk_val({24'h0, tps_pct_o}, 32'h32, "unsaved closed");
		bus_wr(`TSM_REG_TPS_CLOSED, 32'h19);
		for (i = 0; i < 15; i++) begin
			bus_wr(`TSM_REG_SPD_BASE + 12'(4 * i), 32'(1000 * i));
		end
		bus_rd(`TSM_REG_SPD_BASE + 12'h038, rd_val); chk_val(rd_val, 32'h36b0, "speed site 14");
		bus_rd(`TSM_REG_SPD_BASE + 12'h03c, rd_val); chk_val(rd_val, 32'h0, "speed site 15");
		for (i = 0; i < 12; i++) begin
			bus_wr(`TSM_REG_LOAD_BASE + 12'(4 * i), 32'(20 * i));
		end
		for (i = 0; i < 180; i++) begin
			bus_wr(`TSM_REG_MAP_BASE + 12'(4 * i), (i / 12 <= 2) ? 32'h14 : 32'h1a);
		end
		kpa_set <= 8'h1e;
		rpm_set <= 16'd2500;
		wait_map();
		chk_val({24'h0, map_out_o}, 32'h17, "midpoint interpolation");
		rpm_set <= 16'd2250;
		wait_map();
		chk_val({24'h0, map_out_o}, 32'h15, "quarter interpolation");
		bus_wr(`TSM_REG_SETUP, 32'h1);
		wait_map();
		chk_val({24'h0, map_out_o}, 32'h15, "mode before save");
		chk_val({31'h0, map_mode_o}, 32'h0, "mode flag before save");
		save_cfg();
		chk_val({31'h0, map_mode_o}, 32'h1, "mode flag after save");
		wait_map();
		chk_val({24'h0, map_out_o}, 32'h14, "site at or below");
		bus_wr(`TSM_REG_MAP_BASE + 12'(4 * 25), 32'h32);
		wait_map();
		chk_val({24'h0, map_out_o}, 32'h32, "single site edit");
		rpm_set <= 16'hea60;
		wait_map();
		chk_val({24'h0, map_out_o}, 32'h1a, "clamp high");
		rpm_set <= 16'd0;
		wait_map();
		chk_val({24'h0, map_out_o}, 32'h14, "clamp low");
		bus_rd(`TSM_REG_MAP_OUT, rd_val); chk_val(rd_val, 32'h14, "map output register");
		// Throttle at 50 percent lands on load site 2, pressure on site 1
		rpm_set <= 16'd2250;
		bus_wr(`TSM_REG_SETUP, 32'h3);
		save_cfg();
		chk_val({31'h0, load_sel_tps_o}, 32'h1, "load source flag");
		wait_map();
		chk_val({24'h0, map_out_o}, 32'h14, "throttle as load");
		// Reversed pair on purpose: the fault case
		bus_wr(`TSM_REG_TPS_CLOSED, 32'hc8);
		bus_wr(`TSM_REG_TPS_OPEN, 32'h64);
		save_cfg();
		wait_tps();
		chk_val({31'h0, cal_fault_o}, 32'h1, "fault flag");
		chk_val({24'h0, tps_pct_o}, 32'h0, "fault percent");
		bus_rd(`TSM_REG_TPS_PCT, rd_val); chk_val(rd_val, 32'h0, "percent register");
		bus_rd(`TSM_REG_STATUS, rd_val); chk_val(rd_val, 32'h7, "status all set");
		stop_test();
	end
endmodule
